// *** rtl/nbd_ctrl.sv ***
// Dual-port controller sharing the packet buffer between host and network controller.
// Assumes link, strap and controller pins arrive asynchronously; host port is on clock_i.
//
// Overview of operation
// (R1) Device owns the link after power-up; controller masters it only while grant low.
// (R2) Buffer is 8K words of 16-bit RAM on a multiplexed address/data bus.
// (R3) RAM selects come from host strobes or controller byte masks through a multiplexer.
// (R4) Upper RAM select is sampled at power-up as the thin/thick cabling strap.
// (R5) Write strobe pulses low with data valid before its rising edge.
// (R6) Output enable pulses low; read data captured at its rising edge.
// (R7) RAM address latch enable high to follow, low to hold before access.
// (R8) Controller reset asserted on power-up, backplane reset, or software reset write.
// (R9) Grant answers bus request and stays low until the request is removed.
// (R10) Controller latch-enable fall captures address, synchronised, then starts a buffer cycle.
// (R11) Controller latch enable sampled at power-up enables or disables network logic.
// (R12) During controller grant, byte masks drive RAM selects directly. Masks reach the selects only in a controller cycle, three clocks late.
// (R13) Controller interrupt is recorded and forwarded on the programmed level 3 to 6.
// (R14) Read/write line: as master, high requests a buffer read, low a write.
// (R15) As master, data phase follows the controller's latch-enable fall.
// (R16) As master, controller drives bus enable low for the device to drive read data.
// (R17) As master, device drives ready low when it accepts or presents data.
// (R18) Interrupt lines are only driven low, open-collector style.
// (R19) Backplane reset resets all network support logic.
// (R20) A cycle in progress finishes before the other side is granted; no overlap. Grant may fall mid host cycle; access waits for idle.
`timescale 1ns/1ps
`default_nettype none
module nbd_ctrl (
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   powerup_reset_n_i,
   input  wire logic                   backplane_reset_n_i,
   input  wire logic                   soft_net_reset_i,
   input  wire nbd_pkg::nbd_host_req_t host_req_i,
   input  wire logic                   irq_enable_i,
   input  wire logic [1:0]             irq_level_i,
   output logic [15:0]                 host_rdata_o,
   output logic                        host_done_o,
   output logic                        host_busy_o,
   output logic                        thin_cable_o,
   output logic                        net_enable_o,
   output logic                        net_irq_status_o,
   output logic [3:0]                  irq_req_n_o,
   output logic [3:0]                  irq_req_oe_o,
   output logic                        net_ctl_reset_n_o,
   input  wire logic [15:0]            lad_i,
   output logic [15:0]                 lad_o,
   output logic [15:0]                 lad_oe_o,
   input  wire logic                   net_bus_request_n_i,
   output logic                        net_bus_grant_n_o,
   input  wire logic                   net_addr_latch_en_i,
   input  wire logic                   net_byte_mask_upper_n_i,
   input  wire logic                   net_byte_mask_lower_n_i,
   input  wire logic                   net_irq_in_n_i,
   input  wire logic                   net_read_i,
   input  wire logic                   net_bus_dir_enable_n_i,
   output logic                        net_ready_n_o,
   output logic                        net_ready_oe_o,
   input  wire logic [15:0]            sad_i,
   output logic [15:0]                 sad_o,
   output logic [15:0]                 sad_oe_o,
   input  wire logic                   ram_sel_upper_n_i,
   output logic                        ram_sel_upper_n_o,
   output logic                        ram_sel_upper_oe_o,
   output logic                        ram_sel_lower_n_o,
   output logic                        ram_write_n_o,
   output logic                        ram_output_enable_n_o,
   output logic                        ram_addr_latch_en_o
);
   nbd_pkg::nbd_state_reg_t s_reg;
   nbd_pkg::nbd_state_reg_t s_next;

   logic [12:0] lad_addr_latch;
   logic [15:0] sad_sample_reg;
   logic [15:0] lad_sample_reg;
   logic [15:0] sad_sample_next;
   logic [15:0] lad_sample_next;
   logic [15:0] lad_sync_reg;
   logic        net_reset;

   // Power-up, backplane or software reset clear the network section
   assign net_reset = !powerup_reset_n_i || !backplane_reset_n_i || soft_net_reset_i; // R8 R19
   assign lad_addr_latch = lad_sync_reg[12:0];

   // Link word passes two flip-flops; RAM word one, it answers our own strobes
   always_comb begin
      sad_sample_next = sad_i;
      lad_sample_next = lad_i;
   end

   always_comb begin
      s_next = s_reg;
      // Synchronisers for pins from outside the clock domain
      s_next.req_sync       = {s_reg.req_sync[1:0], net_bus_request_n_i};
      s_next.ale_sync       = {s_reg.ale_sync[1:0], net_addr_latch_en_i};
      s_next.rd_sync        = {s_reg.rd_sync[0], net_read_i};
      s_next.bm_u_sync      = {s_reg.bm_u_sync[0], net_byte_mask_upper_n_i};
      s_next.bm_l_sync      = {s_reg.bm_l_sync[0], net_byte_mask_lower_n_i};
      s_next.irq_sync       = {s_reg.irq_sync[0], net_irq_in_n_i};
      s_next.dir_sync       = {s_reg.dir_sync[0], net_bus_dir_enable_n_i};
      s_next.strap_u_sync   = {s_reg.strap_u_sync[0], ram_sel_upper_n_i};
      s_next.strap_ale_sync = {s_reg.strap_ale_sync[0], net_addr_latch_en_i};
      s_next.host_done      = 1'b0;
      s_next.ctl_reset_n    = 1'b1;

      // Straps caught once after release of rst_n_i
      if (!s_reg.strap_done) begin
         s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
         // Only the second synchroniser stage is read
         if (s_reg.strap_cnt == nbd_pkg::STRAP_WAIT) begin
            s_next.strap_done = 1'b1;
            s_next.thin_cable = s_reg.strap_u_sync[1]; // R4
            s_next.net_enable = s_reg.strap_ale_sync[1]; // R11
            s_next.sel_u_oe   = 1'b1; // R4
         end
      end

      // Grant follows request, held until request is removed
      if (!s_reg.net_enable) begin
         s_next.grant_n = 1'b1; // R11
      end else if (!s_reg.req_sync[1]) begin
         s_next.grant_n = 1'b0; // R9 R1
      end else if (s_reg.state == nbd_pkg::NBD_IDLE || s_reg.grant_n) begin
         s_next.grant_n = 1'b1; // R9
      end

      // Interrupt recorded and forwarded on the programmed level
      s_next.irq_status = !s_reg.irq_sync[1] && s_reg.net_enable; // R13
      for (int i = 0; i < nbd_pkg::IRQ_LEVELS; i++) begin
         s_next.irq_n[i] = !(s_reg.irq_status && irq_enable_i
                             && irq_level_i == i[1:0]); // R13 R18
      end

      case (s_reg.state)
         nbd_pkg::NBD_IDLE: begin
            s_next.addr_le  = 1'b1; // R7
            s_next.wr_n     = 1'b1;
            s_next.oe_n     = 1'b1;
            s_next.rdy_n    = 1'b1;
            s_next.rdy_oe   = 1'b0;
            s_next.ram_bus.oe  = 16'h0000;
            s_next.link_bus.oe = 16'h0000;
            s_next.cnt      = nbd_pkg::PHASE_CYCLES;
            // Falling latch enable during grant starts a controller cycle
            if (s_reg.net_enable && !s_reg.grant_n && s_reg.ale_sync[2]
                && !s_reg.ale_sync[1]) begin // R10 R15
               s_next.owner_net = 1'b1;
               s_next.grant_int = 1'b1; // R10
               s_next.net_write = !s_reg.rd_sync[1]; // R14
               s_next.net_addr  = lad_addr_latch; // R10
               s_next.ram_bus.o  = {3'h0, lad_addr_latch};
               s_next.ram_bus.oe = 16'hffff;
               s_next.state     = nbd_pkg::NBD_ADDR;
            end else if (host_req_i.req && s_reg.grant_n) begin // R20
               s_next.owner_net    = 1'b0;
               s_next.grant_int    = 1'b0;
               s_next.host_write   = host_req_i.write;
               s_next.host_addr    = host_req_i.addr;
               s_next.host_wdata   = host_req_i.wdata;
               s_next.host_sel_u_n = host_req_i.sel_upper_n;
               s_next.host_sel_l_n = host_req_i.sel_lower_n;
               s_next.ram_bus.o    = {3'h0, host_req_i.addr}; // R2
               s_next.ram_bus.oe   = 16'hffff;
               s_next.state        = nbd_pkg::NBD_ADDR;
            end
         end
         nbd_pkg::NBD_ADDR: begin
            // Address held in the external latch before access
            s_next.addr_le = 1'b0; // R7
            s_next.state   = nbd_pkg::NBD_ACCESS;
         end
         nbd_pkg::NBD_ACCESS: begin
            if (s_reg.owner_net ? s_reg.net_write : s_reg.host_write) begin
               s_next.ram_bus.o  = s_reg.owner_net ? lad_sync_reg : s_reg.host_wdata;
               s_next.ram_bus.oe = 16'hffff;
               s_next.wr_n       = 1'b0; // R5
            end else begin
               s_next.ram_bus.oe = 16'h0000;
               s_next.oe_n       = 1'b0; // R6
            end
            s_next.state = nbd_pkg::NBD_STROBE;
         end
         nbd_pkg::NBD_STROBE: begin
            s_next.cnt = s_reg.cnt - 2'h1;
            if (s_reg.cnt == 2'h1) begin
               // Strobes rise with data still held on the RAM bus
               s_next.wr_n = 1'b1; // R5
               s_next.oe_n = 1'b1; // R6
               if (!s_reg.oe_n) begin
                  s_next.rdata = sad_sample_reg; // R6
               end
               s_next.state = nbd_pkg::NBD_DONE;
            end
         end
         nbd_pkg::NBD_DONE: begin
            s_next.ram_bus.oe = 16'h0000;
            if (s_reg.owner_net) begin
               // Ready low to the controller; read data driven when it enables us
               s_next.rdy_n  = 1'b0; // R17
               s_next.rdy_oe = 1'b1; // R17
               s_next.link_bus.o  = s_reg.rdata;
               s_next.link_bus.oe = (!s_reg.net_write && !s_reg.dir_sync[1])
                                    ? 16'hffff : 16'h0000; // R16
               s_next.state  = nbd_pkg::NBD_WAIT;
            end else begin
               s_next.host_done = 1'b1;
               s_next.state     = nbd_pkg::NBD_IDLE;
            end
         end
         nbd_pkg::NBD_WAIT: begin
            s_next.link_bus.oe = (!s_reg.net_write && !s_reg.dir_sync[1])
                                 ? 16'hffff : 16'h0000; // R16
            // Controller cycle ends when its latch enable rises again
            if (s_reg.ale_sync[1] || s_reg.grant_n) begin
               s_next.rdy_n       = 1'b1;
               s_next.rdy_oe      = 1'b0;
               s_next.link_bus.oe = 16'h0000;
               s_next.grant_int   = 1'b0;
               s_next.state       = nbd_pkg::NBD_IDLE; // R20
            end
         end
         default: begin
            s_next.state = nbd_pkg::NBD_IDLE;
         end
      endcase

      // Select multiplexer: byte masks in a controller cycle, host strobes in a host cycle, else deasserted
      if (s_reg.grant_int) begin
         s_next.sel_u_n = s_reg.bm_u_sync[1]; // R12 R3
         s_next.sel_l_n = s_reg.bm_l_sync[1]; // R12 R3
      end else if (s_reg.state != nbd_pkg::NBD_IDLE) begin
         s_next.sel_u_n = s_reg.host_sel_u_n; // R3
         s_next.sel_l_n = s_reg.host_sel_l_n; // R3
      end else begin
         s_next.sel_u_n = 1'b1;
         s_next.sel_l_n = 1'b1;
      end

      if (net_reset) begin
         s_next.ctl_reset_n = 1'b0; // R8
         s_next.state       = nbd_pkg::NBD_IDLE; // R19
         s_next.grant_n     = 1'b1; // R1
         s_next.grant_int   = 1'b0;
         s_next.irq_status  = 1'b0;
         s_next.irq_n       = 4'hf;
         s_next.link_bus.oe = 16'h0000; // R1
         s_next.rdy_oe      = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         s_reg <= '{state: nbd_pkg::NBD_IDLE, cnt: nbd_pkg::PHASE_CYCLES,
                    host_addr: nbd_pkg::ADDR_RST, net_addr: nbd_pkg::ADDR_RST,
                    host_wdata: nbd_pkg::DATA_RST, rdata: nbd_pkg::DATA_RST,
                    ram_bus: '0, link_bus: '0, req_sync: 3'h7, ale_sync: 3'h7,
                    irq_sync: 2'h3, irq_n: 4'hf, grant_n: 1'b1, ctl_reset_n: 1'b0,
                    dir_sync: 2'h3, bm_u_sync: 2'h3, bm_l_sync: 2'h3,
                    sel_u_n: 1'b1, sel_l_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1,
                    rdy_n: 1'b1, addr_le: 1'b1, host_sel_u_n: 1'b1,
                    host_sel_l_n: 1'b1, default: '0};
         sad_sample_reg <= nbd_pkg::DATA_RST;
         lad_sample_reg <= nbd_pkg::DATA_RST;
         lad_sync_reg   <= nbd_pkg::DATA_RST;
      end else begin
         s_reg          <= s_next;
         sad_sample_reg <= sad_sample_next;
         lad_sample_reg <= lad_sample_next;
         lad_sync_reg   <= lad_sample_reg;
      end
   end

   assign host_rdata_o          = s_reg.rdata;
   assign host_done_o           = s_reg.host_done;
   assign host_busy_o           = s_reg.state != nbd_pkg::NBD_IDLE;
   assign thin_cable_o          = s_reg.thin_cable;
   assign net_enable_o          = s_reg.net_enable;
   assign net_irq_status_o      = s_reg.irq_status;
   assign irq_req_n_o           = 4'h0; // R18
   assign irq_req_oe_o          = ~s_reg.irq_n; // R18
   assign net_ctl_reset_n_o     = s_reg.ctl_reset_n;
   assign lad_o                 = s_reg.link_bus.o;
   assign lad_oe_o              = s_reg.link_bus.oe;
   assign net_bus_grant_n_o     = s_reg.grant_n;
   assign net_ready_n_o         = s_reg.rdy_n;
   assign net_ready_oe_o        = s_reg.rdy_oe;
   assign sad_o                 = s_reg.ram_bus.o;
   assign sad_oe_o              = s_reg.ram_bus.oe;
   assign ram_sel_upper_n_o     = s_reg.sel_u_n;
   assign ram_sel_upper_oe_o    = s_reg.sel_u_oe;
   assign ram_sel_lower_n_o     = s_reg.sel_l_n;
   assign ram_write_n_o         = s_reg.wr_n;
   assign ram_output_enable_n_o = s_reg.oe_n;
   assign ram_addr_latch_en_o   = s_reg.addr_le;
endmodule
`default_nettype wire

// *** rtl/nbd_pkg.sv ***
// Package for the network packet buffer dual-port controller.
// Assumes one 40 MHz clock; all timing counts are in clock cycles.
package nbd_pkg;
   localparam int          ADDR_W        = 13;
   localparam int          DATA_W        = 16;
   localparam int          IRQ_LEVELS    = 4;
   localparam logic [1:0]  IRQ_LVL_RST   = 2'h0;
   localparam logic [15:0] DATA_RST      = 16'h0000;
   localparam logic [12:0] ADDR_RST      = 13'h0000;
   // Cycles the RAM write or output-enable strobe is held low
   localparam logic [1:0]  PHASE_CYCLES  = 2'h2;
   // Cycles until both strap synchronisers hold the pin level
   localparam logic [1:0]  STRAP_WAIT    = 2'h2;

   typedef enum logic [5:0] {
      NBD_IDLE   = 6'b00_0001,
      NBD_ADDR   = 6'b00_0010,
      NBD_ACCESS = 6'b00_0100,
      NBD_STROBE = 6'b00_1000,
      NBD_DONE   = 6'b01_0000,
      NBD_WAIT   = 6'b10_0000
   } nbd_state_t;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [12:0] addr;
      logic [15:0] wdata;
      logic        sel_upper_n;
      logic        sel_lower_n;
   } nbd_host_req_t;

   typedef struct packed {
      logic [15:0] o;
      logic [15:0] oe;
   } nbd_bus_drv_t;

   typedef struct packed {
      nbd_state_t   state;
      logic [1:0]   cnt;
      logic         owner_net;
      logic         host_write;
      logic [12:0]  host_addr;
      logic [15:0]  host_wdata;
      logic         host_sel_u_n;
      logic         host_sel_l_n;
      logic         net_write;
      logic [12:0]  net_addr;
      logic         grant_n;
      logic         grant_int;
      logic [2:0]  req_sync;
      logic [2:0]  ale_sync;
      logic [1:0]  rd_sync;
      logic [1:0]  bm_u_sync;
      logic [1:0]  bm_l_sync;
      logic [1:0]  irq_sync;
      logic [1:0]  strap_u_sync;
      logic [1:0]  strap_ale_sync;
      logic [1:0]  strap_cnt;
      logic [1:0]  dir_sync;
      logic        strap_done;
      logic        thin_cable;
      logic        net_enable;
      logic        irq_status;
      logic [3:0]  irq_n;
      logic        ctl_reset_n;
      logic        sel_u_n;
      logic        sel_l_n;
      logic        sel_u_oe;
      logic        wr_n;
      logic        oe_n;
      logic        addr_le;
      nbd_bus_drv_t ram_bus;
      nbd_bus_drv_t link_bus;
      logic        rdy_n;
      logic        rdy_oe;
      logic [15:0] rdata;
      logic        host_done;
   } nbd_state_reg_t;
endpackage

// *** testbench/nbd_ctrl_chk.sv ***
// Port assertions for the dual-port packet buffer controller.
// Assumes a bind onto nbd_ctrl; one clock, synchronous low reset.
`timescale 1ns/1ps
`default_nettype none
module nbd_ctrl_chk (
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   input wire logic        powerup_reset_n_i,
   input wire logic        backplane_reset_n_i,
   input wire logic        soft_net_reset_i,
   input wire logic        irq_enable_i,
   input wire logic [3:0]  irq_req_n_o,
   input wire logic [3:0]  irq_req_oe_o,
   input wire logic        net_ctl_reset_n_o,
   input wire logic        net_enable_o,
   input wire logic        net_bus_request_n_i,
   input wire logic        net_bus_grant_n_o,
   input wire logic        net_byte_mask_upper_n_i,
   input wire logic        net_byte_mask_lower_n_i,
   input wire logic [15:0] sad_o,
   input wire logic [15:0] sad_oe_o,
   input wire logic        ram_sel_upper_n_o,
   input wire logic        ram_sel_lower_n_o,
   input wire logic        ram_write_n_o,
   input wire logic        ram_output_enable_n_o,
   input wire logic        ram_addr_latch_en_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic net_ok;
   assign net_ok = powerup_reset_n_i && backplane_reset_n_i && !soft_net_reset_i;
   a_grant_answer: assert property ((net_enable_o && net_ok && !net_bus_request_n_i) [*8]
      |-> ##[0:4] !net_bus_grant_n_o) else $error("grant not given");
   a_grant_hold: assert property (!net_bus_grant_n_o && !net_bus_request_n_i && net_ok
      |=> !net_bus_grant_n_o) else $error("grant dropped under request");
   a_no_overlap: assert property (!ram_write_n_o |-> ram_output_enable_n_o)
      else $error("read and write strobes overlap");
   a_wr_width: assert property ($fell(ram_write_n_o) |-> !ram_write_n_o [*2] ##1 ram_write_n_o)
      else $error("write strobe width wrong");
   a_wr_data: assert property ($rose(ram_write_n_o)
      |-> $past(sad_oe_o) == 16'hFFFF && $past(sad_o) == $past(sad_o, 2))
      else $error("write data not steady before strobe end");
   a_rd_bus_free: assert property (!ram_output_enable_n_o |-> sad_oe_o == 16'h0000)
      else $error("RAM bus driven during read");
   a_ale_closed: assert property (($fell(ram_write_n_o) || $fell(ram_output_enable_n_o))
      |-> !ram_addr_latch_en_o && !$past(ram_addr_latch_en_o)) else $error("address latch open");
   a_mask_route: assert property (!net_bus_grant_n_o && $past(!net_bus_grant_n_o, 8)
      && !(ram_write_n_o && ram_output_enable_n_o)
      |-> ram_sel_upper_n_o == $past(net_byte_mask_upper_n_i, 3)
      && ram_sel_lower_n_o == $past(net_byte_mask_lower_n_i, 3)) else $error("byte masks not routed");
   a_ctl_reset: assert property (!net_ok |-> ##[1:3] !net_ctl_reset_n_o)
      else $error("controller reset not asserted");
   a_irq_low_only: assert property (irq_req_n_o == 4'h0) else $error("irq line driven high");
   a_irq_one_line: assert property (|irq_req_oe_o
      |-> $onehot(irq_req_oe_o) && ($past(irq_enable_i) || $past(irq_enable_i, 2)))
      else $error("irq request wrong");
   c_host_write: cover property ($rose(ram_write_n_o) && net_bus_grant_n_o);
   c_net_read: cover property (!net_bus_grant_n_o && !ram_output_enable_n_o);
   c_irq: cover property (|irq_req_oe_o);
endmodule
`default_nettype wire

// *** testbench/nbd_sram_model.sv ***
// Two buffer RAM chips behind an address latch, bus pulled up.
// Assumes the controller's RAM strobes; strap level is a parameter.
`timescale 1ns/1ps
`default_nettype none
module nbd_sram_model #(
   parameter logic STRAP_UP = 1'h1
) (
   input  wire logic        clk_i,
   input  wire logic [15:0] drv_i,
   input  wire logic [15:0] drv_en_i,
   output logic [15:0]      bus_o,
   input  wire logic        sel_u_n_i,
   input  wire logic        sel_u_en_i,
   output logic             sel_u_o,
   input  wire logic        sel_l_n_i,
   input  wire logic        wr_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        ale_i
);
   logic [15:0] mem [0:8191];
   logic [12:0] addr;
   logic [15:0] rd;
   logic [15:0] wd;
   logic        su;
   logic        sl;
   assign sel_u_o = sel_u_en_i ? sel_u_n_i : STRAP_UP;
   assign rd = oe_n_i ? 16'hFFFF : {sel_u_o ? 8'hFF : mem[addr][15:8],
                                    sel_l_n_i ? 8'hFF : mem[addr][7:0]};
   assign bus_o = (drv_i & drv_en_i) | (rd & ~drv_en_i);
   always @* if (ale_i) addr = bus_o[12:0];
   always @(negedge clk_i) if (!wr_n_i) begin
      wd <= bus_o;
      su <= sel_u_o;
      sl <= sel_l_n_i;
   end
   always @(posedge wr_n_i) begin
      if (!sl) mem[addr][7:0] = wd[7:0];
      if (!su) mem[addr][15:8] = wd[15:8];
   end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the dual-port packet buffer controller.
// Assumes the RAM model on the buffer side; bench plays the controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clock_i, rst_n_i, powerup_reset_n_i, backplane_reset_n_i, soft_net_reset_i;
   logic irq_enable_i, host_done_o, host_busy_o, thin_cable_o, net_enable_o, net_irq_status_o;
   logic [1:0] irq_level_i;
   logic [3:0] irq_req_n_o, irq_req_oe_o;
   nbd_pkg::nbd_host_req_t host_req_i;
   logic [15:0] host_rdata_o, lad_i, lad_o, lad_oe_o, sad_i, sad_o, sad_oe_o, lad_drv;
   logic net_ctl_reset_n_o, net_bus_request_n_i, net_bus_grant_n_o, net_addr_latch_en_i;
   logic net_byte_mask_upper_n_i, net_byte_mask_lower_n_i, net_irq_in_n_i, net_read_i;
   logic net_bus_dir_enable_n_i, net_ready_n_o, net_ready_oe_o, ram_sel_upper_n_i;
   logic ram_sel_upper_n_o, ram_sel_upper_oe_o, ram_sel_lower_n_o, ram_write_n_o;
   logic ram_output_enable_n_o, ram_addr_latch_en_o, hit;
   int bad_count = 0;
   int n_checks = 0;
   nbd_ctrl i_nbd_ctrl (.*);
   nbd_sram_model i_nbd_sram_model (.clk_i(clock_i), .drv_i(sad_o), .drv_en_i(sad_oe_o),
      .bus_o(sad_i), .sel_u_n_i(ram_sel_upper_n_o), .sel_u_en_i(ram_sel_upper_oe_o),
      .sel_u_o(ram_sel_upper_n_i), .sel_l_n_i(ram_sel_lower_n_o), .wr_n_i(ram_write_n_o),
      .oe_n_i(ram_output_enable_n_o), .ale_i(ram_addr_latch_en_o));
   assign lad_i = (lad_o & lad_oe_o) | (lad_drv & ~lad_oe_o);
   always #12.5 clock_i = ~clock_i;
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock_i);
      #2;
   endtask
   task automatic stop_test();
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic host(input logic wr, input logic [12:0] a, input logic [15:0] d,
                       input logic [1:0] sel);
      int w;
      host_req_i = '{1'h1, wr, a, d, sel[1], sel[0]};
      for (w = 0; w < 60 && host_done_o !== 1'h1; w++) tick();
      `CHK("host_done", 1'h1, host_done_o)
      `CHK("host_idle", 1'h0, host_busy_o)
      host_req_i.req = 1'h0;
      tick();
   endtask
   task automatic net(input logic wr, input logic [12:0] a, input logic [15:0] d);
      int w;
      net_bus_request_n_i = 1'h0;
      for (w = 0; w < 20 && net_bus_grant_n_o !== 1'h0; w++) tick();
      `CHK("grant", 1'h0, net_bus_grant_n_o)
      lad_drv = {3'h0, a};
      net_read_i = !wr;
      net_byte_mask_upper_n_i = 1'h0;
      net_byte_mask_lower_n_i = 1'h0;
      tick(4);
      net_addr_latch_en_i = 1'h0;
      tick(2);
      lad_drv = wr ? d : 16'hFFFF;
      net_bus_dir_enable_n_i = wr;
      for (w = 0; w < 20 && net_ready_n_o !== 1'h0; w++) tick();
      `CHK("ready", 1'h0, net_ready_n_o)
      `CHK("ready_oe", 1'h1, net_ready_oe_o)
      `CHK("lad_oe", wr ? 16'h0000 : 16'hFFFF, lad_oe_o)
      `CHK("net_busy", 1'h1, host_busy_o)
      if (!wr) `CHK("lad", d, lad_i)
      net_addr_latch_en_i = 1'h1;
      net_bus_dir_enable_n_i = 1'h1;
      net_byte_mask_upper_n_i = 1'h1;
      net_byte_mask_lower_n_i = 1'h1;
      lad_drv = 16'hFFFF;
      tick(4);
   endtask
   initial begin
      {clock_i, rst_n_i, powerup_reset_n_i, soft_net_reset_i, irq_enable_i} = 5'h00;
      {backplane_reset_n_i, net_bus_request_n_i, net_addr_latch_en_i, net_irq_in_n_i} = 4'hF;
      {net_byte_mask_upper_n_i, net_byte_mask_lower_n_i, net_read_i} = 3'h7;
      net_bus_dir_enable_n_i = 1'h1;
      irq_level_i = 2'h0;
      host_req_i = '0;
      lad_drv = 16'hFFFF;
      tick(20);
      rst_n_i = 1'h1;
      powerup_reset_n_i = 1'h1;
      tick(8);
      `CHK("thin_cable", 1'h1, thin_cable_o)
      `CHK("strap_oe", 1'h1, ram_sel_upper_oe_o)
      `CHK("net_enable", 1'h1, net_enable_o)
      `CHK("ctl_reset", 1'h1, net_ctl_reset_n_o)
      host(1'h1, 13'h1FFF, 16'hA5C3, 2'h0);
      host(1'h1, 13'h1FFF, 16'h12FF, 2'h1);
      host(1'h0, 13'h1FFF, 16'h0000, 2'h0);
      `CHK("byte_write", 16'h12C3, host_rdata_o)
      net(1'h1, 13'h0040, 16'h5A0F);
      host_req_i = '{1'h1, 1'h0, 13'h0040, 16'h0000, 1'h0, 1'h0};
      hit = 1'h0;
      repeat (10) begin
         tick();
         if (host_done_o !== 1'h0) hit = 1'h1;
      end
      `CHK("host_held_off", 1'h0, hit)
      net(1'h0, 13'h0040, 16'h5A0F);
      net_bus_request_n_i = 1'h1;
      host(1'h0, 13'h0040, 16'h0000, 2'h0);
      `CHK("net_written", 16'h5A0F, host_rdata_o)
      `CHK("grant_off", 1'h1, net_bus_grant_n_o)
      net_irq_in_n_i = 1'h0;
      irq_enable_i = 1'h1;
      for (int l = 0; l < 4; l++) begin
         irq_level_i = 2'(l);
         tick(4);
         `CHK("irq_line", 4'h1 << l, irq_req_oe_o)
      end
      `CHK("irq_status", 1'h1, net_irq_status_o)
      irq_enable_i = 1'h0;
      tick(4);
      `CHK("irq_masked", 4'h0, irq_req_oe_o)
      net_irq_in_n_i = 1'h1;
      soft_net_reset_i = 1'h1;
      tick(3);
      `CHK("soft_reset", 1'h0, net_ctl_reset_n_o)
      soft_net_reset_i = 1'h0;
      tick(8);
      `CHK("reset_off", 1'h1, net_ctl_reset_n_o)
      backplane_reset_n_i = 1'h0;
      tick(3);
      `CHK("bp_reset", 1'h0, net_ctl_reset_n_o)
      backplane_reset_n_i = 1'h1;
      tick(10);
      stop_test();
   end
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule
bind nbd_ctrl nbd_ctrl_chk i_nbd_ctrl_chk (.*);
`default_nettype wire
